/* File: dv/core_model.sv */
/* core side model: presents the executing pc one cycle after a fetch request.
   assumes one clock, ref_clk; an idle pc flips every cycle with pc_valid low, so stale values never count. */
`timescale 1ns/1ps
module core_model (
    input  wire logic        ref_clk,    // core clock
    input  wire logic [31:0] fetch_addr, // next instruction address
    input  wire logic        fetch_en,   // execute one instruction
    output logic      [31:0] pc,         // program counter to the block
    output logic             pc_valid    // pc is executing
);
    // ============================================================
    // pc register, flips while idle
    always_ff @(posedge ref_clk) begin
        pc       <= fetch_en ? fetch_addr : ~pc;
        pc_valid <= fetch_en;
    end
endmodule // core_model

/* File: dv/pc_breakpoint_trigger_control_tb.sv */
/* self-checking bench: host and supervisor writes, host reads, pc and data triggers.
   assumes the register map header and core_model; ref_clk 250 MHz. */
`timescale 1ns/1ps
`include "pc_trig_map.svh"
module pc_breakpoint_trigger_control_tb;
    logic ref_clk = 0, rst_n = 0, hw = 0, sw = 0, hr = 0, fe = 0, dv = 0, xg = 0;
    logic [4:0] hn = 0, sn = 0, rn = 0;
    logic [31:0] hd = 0, sd = 0, fa = 0, pc, db = 0, rdd;
    logic [1:0] ds = 0, da = 0;
    logic pcv, rdv, ts, hq, di;
    logic [3:0] st, tc;
    int fail_count = 0, tests_run = 0, cyc = 0;
    always #2 ref_clk = ~ref_clk;
    core_model core_model_i (.ref_clk(ref_clk), .fetch_addr(fa), .fetch_en(fe), .pc(pc), .pc_valid(pcv));
    pc_breakpoint_trigger_control pc_breakpoint_trigger_control_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .pc(pc), .pc_valid(pcv), .data_bus(db), .data_addr(da), .data_size(ds), .data_valid(dv),
        .data_match_value(32'h1234_5678), .data_match_mask(32'h0000_0000), .ext_global_enable(xg),
        .supervisor_debug_write(sw), .supervisor_debug_num(sn), .supervisor_debug_data(sd),
        .host_register_write(hw), .host_register_num(hn), .host_register_data(hd),
        .host_register_read(hr), .host_read_num(rn), .host_read_data(rdd), .host_read_valid(rdv),
        .trigger_status_field(st), .trace_status_output(tc), .trace_strobe(ts),
        .halt_request(hq), .debug_interrupt(di));
    // ============================================================
    // shared tasks
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // write through host port, or supervisor port when s is set
    task wr(input logic s, input logic [4:0] n, input logic [31:0] d);
        @(posedge ref_clk);
        if (s) begin sw <= 1; sn <= n; sd <= d; end
        else begin hw <= 1; hn <= n; hd <= d; end
        @(posedge ref_clk);
        sw <= 0;
        hw <= 0;
    endtask
    task rd(input logic [4:0] n, input logic [31:0] e);
        @(posedge ref_clk);
        hr <= 1; rn <= n;
        @(posedge ref_clk);
        hr <= 0;
        #1 chk(rdv, 1);
        chk(rdd, e);
    endtask
    // one instruction at address a; p = strobe, halt, interrupt
    task step(input logic [31:0] a, input logic [3:0] s, input logic [2:0] p);
        @(posedge ref_clk);
        fa <= a; fe <= 1;
        @(posedge ref_clk);
        fe <= 0;
        @(posedge ref_clk);
        #1 chk({ts, hq, di}, p);
        chk(st, s);
        chk(tc, p[2] ? s : 4'h0);
    endtask
    task results;
        $display("tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hang guard, well above the roughly 80 cycles needed
    always @(posedge ref_clk) if (++cyc == 2000) begin fail_count++; results; end
    // ============================================================
    // test sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1;
        #1 chk({st, tc, ts, hq, di}, 0);
        wr(0, `RN_PC_MATCH_PRIMARY, 32'h0000_1001);
        rd(`RN_PC_MATCH_PRIMARY, 32'h0000_1000);
        wr(1, `RN_PC_MATCH_MASK, 32'h0000_00F0);
        rd(`RN_PC_MATCH_MASK, 0);
        rd(5'h03, 0);
        $display("registers done");
        wr(0, `RN_TRIGGER_SETUP, 32'h4000_2002);
        step(32'h0000_10F0, 1, 3'b110);
        step(32'h0000_1000, 1, 0);
        wr(1, `RN_TRIGGER_SETUP, 32'h8000_2002);
        #1 chk(st, 0);
        step(32'h0000_1100, 0, 0);
        wr(0, `RN_PC_MATCH_SECOND, 32'h0000_2000);
        step(32'h0000_2000, 0, 0);
        wr(0, `RN_PC_MATCH_SECOND, 32'h0000_2001);
        step(32'h0000_20F0, 0, 0);
        step(32'h0000_2000, 1, 3'b101);
        wr(0, `RN_TRIGGER_SETUP, 32'h0000_0002);
        step(32'h0000_1000, 0, 0);
        $display("one level done");
        wr(0, `RN_PC_MATCH_THIRD, 32'h0000_3001);
        wr(0, `RN_TRIGGER_SETUP, 32'h0002_2002);
        step(32'h0000_1000, 2, 0);
        step(32'h0000_3000, 5, 3'b100);
        $display("two level done");
        @(posedge ref_clk);
        db <= 32'h1234_5678; ds <= 2'h2; dv <= 1;
        wr(0, `RN_TRIGGER_SETUP, 32'hC000_3000);
        @(posedge ref_clk);
        #1 chk({ts, hq, di, st}, {3'b100, 4'h1});
        @(posedge ref_clk);
        ds <= 2'h0;
        wr(0, `RN_TRIGGER_SETUP, 32'h0000_2060);
        repeat (2) @(posedge ref_clk);
        #1 chk({ts, st}, 0);
        @(posedge ref_clk);
        db <= 32'hFF34_5678;
        @(posedge ref_clk);
        #1 chk({ts, st}, {1'b1, 4'h1});
        $display("data done");
        wr(0, `RN_TRIGGER_SETUP, 32'h0000_2003);
        step(32'h0000_1000, 0, 0);
        step(32'h0000_5000, 1, 3'b100);
        wr(0, `RN_TRIGGER_SETUP, 32'h0000_0002);
        xg <= 1;
        step(32'h0000_1000, 1, 3'b100);
        $display("invert and extended enable done");
        @(posedge ref_clk);
        rst_n <= 0;
        @(posedge ref_clk);
        rst_n <= 1;
        #1 chk({st, tc, ts, hq, di}, 0);
        rd(`RN_PC_MATCH_PRIMARY, 0);
        $display("reset done");
        results;
    end
endmodule // pc_breakpoint_trigger_control_tb

/* File: inc/pc_trig_map.svh */
/*
 * register numbers, field positions, reset values and status codes of the
 * pc breakpoint trigger control block.
 * assumes inclusion by bare name from the design files.
 */
`ifndef PC_TRIG_MAP_SVH
`define PC_TRIG_MAP_SVH
// ============================================================
// debug control register numbers
`define RN_PC_MATCH_MASK    5'h09
`define RN_PC_MATCH_PRIMARY 5'h08
`define RN_PC_MATCH_SECOND  5'h18
`define RN_PC_MATCH_THIRD   5'h1A
`define RN_PC_MATCH_FOURTH  5'h1B
`define RN_TRIGGER_SETUP    5'h07
// ============================================================
// trigger setup fields, HALF_ positions within one 16-bit half, TRC_ in the whole word; PC_VALID in the secondary registers
`define TRC_HI      31
`define TRC_LO      30
`define HALF_EBL    13
`define HALF_ED_HI  12
`define HALF_ED_LO  6
`define HALF_DI     5
`define HALF_EPC    1
`define HALF_PCI    0
`define PC_VALID    0
// ============================================================
// reset values, response codes, status codes
`define REG_RST     32'h0000_0000
`define TRC_DISPLAY 2'h0
`define TRC_HALT    2'h1
`define TRC_IRQ     2'h2
`define ST_IDLE     4'h0
`define ST_L1_DONE  4'h1
`define ST_L2_ARMED 4'h2
`define ST_L2_DONE  4'h5
`endif

/* File: inc/pc_trig_pkg.sv */
/*
 * types used by the trigger control for its sequencer and level decode.
 * assumes nothing of its surroundings.
 */
package pc_trig_pkg;
    // ============================================================
    // trigger sequencer and one level's decoded setup
    typedef enum logic [1:0] {ARM_FIRST, ARM_SECOND, FIRED} arm_level_e;
    typedef struct packed {
        logic [6:0] data_en;
        logic       data_inv;
        logic       pc_en;
        logic       pc_inv;
    } level_cfg_s;
endpackage

/* File: inc/trig_cfg_if.sv */
/*
 * bundle between the trigger control and its pc and data match units.
 * assumes all signals are in the ref_clk domain.
 */
`timescale 1ns/1ps
interface trig_cfg_if;
    logic [31:0] pc_now;
    logic [31:0] pc_prim;
    logic [31:0] pc_sec [3];
    logic [31:0] pc_mask;
    logic        pc_hit;
    logic [31:0] bus_data;
    logic [31:0] cmp_value;
    logic [31:0] cmp_mask;
    logic [1:0]  bus_addr;
    logic [1:0]  bus_size;
    logic        bus_valid;
    logic [6:0]  lane_app;
    logic [6:0]  lane_eq;
    modport ctl (output pc_now, pc_prim, pc_sec, pc_mask, bus_data, cmp_value, cmp_mask,
                 bus_addr, bus_size, bus_valid, input pc_hit, lane_app, lane_eq);
    modport pcu (input pc_now, pc_prim, pc_sec, pc_mask, output pc_hit);
    modport dmu (input bus_data, cmp_value, cmp_mask, bus_addr, bus_size, bus_valid,
                 output lane_app, lane_eq);
endinterface // trig_cfg_if

/* File: rtl/data_match_unit.sv */
/*
 * combinational data lane compare for seven size and placement lanes.
 * assumes size 0 byte, 1 word, 2 longword; lanes ordered as the enable field.
 */
`timescale 1ns/1ps
module data_match_unit (
    input  wire logic ref_clk,   // clock, checks only
    input  wire logic rst_n,     // reset, checks only
    trig_cfg_if.dmu   cfg        // bus and compare values
);
    // ============================================================
    // masked difference, set mask bits are ignored
    wire [31:0] diff   = (cfg.bus_data ^ cfg.cmp_value) & ~cfg.cmp_mask;
    wire        is_b   = cfg.bus_valid && (cfg.bus_size == 2'h0);
    wire        is_w   = cfg.bus_valid && (cfg.bus_size == 2'h1);
    wire        is_l   = cfg.bus_valid && (cfg.bus_size == 2'h2);
    // lane 6 long, 5 low word, 4 high word, 3..0 bytes low to high
    assign cfg.lane_eq  = {diff == 32'h0000_0000, diff[15:0] == 16'h0000, diff[31:16] == 16'h0000,
                           diff[7:0] == 8'h00, diff[15:8] == 8'h00, diff[23:16] == 8'h00,
                           diff[31:24] == 8'h00};
    assign cfg.lane_app = {is_l, is_w & cfg.bus_addr[1], is_w & ~cfg.bus_addr[1],
                           is_b & (cfg.bus_addr == 2'h3), is_b & (cfg.bus_addr == 2'h2),
                           is_b & (cfg.bus_addr == 2'h1), is_b & (cfg.bus_addr == 2'h0)};

    chk_long_lane_hit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (is_l && cfg.bus_data == cfg.cmp_value) |-> (cfg.lane_app == 7'h40 && cfg.lane_eq[6]))
        else $error("longword lane wrong");
    chk_top_byte_lane: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (is_b && cfg.bus_addr == 2'h0) |-> (cfg.lane_app == 7'h01)) else $error("byte lane wrong");
endmodule // data_match_unit

/* File: rtl/pc_breakpoint_trigger_control.sv */
/*
 * pc breakpoint registers, trigger setup and the one- or two-level trigger
 * sequencer with its response outputs.
 * assumes the core supplies pc and local bus on ref_clk; data compare value
 * and mask, and the extended enable, come from registers kept elsewhere.
 */
`timescale 1ns/1ps
`include "pc_trig_map.svh"
module pc_breakpoint_trigger_control (
    input  wire logic        ref_clk,               // 250 MHz core clock
    input  wire logic        rst_n,                 // async reset, active low
    input  wire logic [31:0] pc,                    // executing program counter
    input  wire logic        pc_valid,              // pc holds an executing instruction
    input  wire logic [31:0] data_bus,              // local data bus
    input  wire logic [1:0]  data_addr,             // access address bits 1..0
    input  wire logic [1:0]  data_size,             // 0 byte, 1 word, 2 longword
    input  wire logic        data_valid,            // data bus holds an operand
    input  wire logic [31:0] data_match_value,      // data compare value
    input  wire logic [31:0] data_match_mask,       // data compare mask, set ignores
    input  wire logic        ext_global_enable,     // global enable of extended setup
    input  wire logic        supervisor_debug_write,// supervisor register write strobe
    input  wire logic [4:0]  supervisor_debug_num,  // supervisor register number
    input  wire logic [31:0] supervisor_debug_data, // supervisor write data
    input  wire logic        host_register_write,   // debug host write strobe
    input  wire logic [4:0]  host_register_num,     // debug host register number
    input  wire logic [31:0] host_register_data,    // debug host write data
    input  wire logic        host_register_read,    // debug host read strobe
    input  wire logic [4:0]  host_read_num,         // debug host read number
    output logic      [31:0] host_read_data,        // read data, one cycle later
    output logic             host_read_valid,       // read data valid pulse
    output logic      [3:0]  trigger_status_field,  // trigger status to config register
    output logic      [3:0]  trace_status_output,   // status code on completion
    output logic             trace_strobe,          // completion pulse on trace
    output logic             halt_request,          // processor halt pulse
    output logic             debug_interrupt        // debug interrupt pulse
);
    // ============================================================
    // decode helpers
    // one setup half into enables and inverts
    function automatic pc_trig_pkg::level_cfg_s half_cfg(input logic [15:0] h);
        pc_trig_pkg::level_cfg_s c;
        c.data_en  = h[`HALF_ED_HI:`HALF_ED_LO];
        c.data_inv = h[`HALF_DI];
        c.pc_en    = h[`HALF_EPC];
        c.pc_inv   = h[`HALF_PCI];
        return c;
    endfunction

    // a level is met when at least one condition is enabled and every enabled one holds
    function automatic logic level_met(input pc_trig_pkg::level_cfg_s c, input logic hit,
                                       input logic pcv, input logic [6:0] app,
                                       input logic [6:0] eq);
        logic pc_ok;
        logic dat_ok;
        logic dat_on;
        pc_ok  = pcv & (hit ^ c.pc_inv);
        dat_on = |c.data_en;
        dat_ok = |(c.data_en & app & (eq ^ {7{c.data_inv}}));
        return (c.pc_en | dat_on) & (~c.pc_en | pc_ok) & (~dat_on | dat_ok);
    endfunction

    // ============================================================
    // register write port
    // host wins a same-cycle collision
    wire         wr_en   = host_register_write | supervisor_debug_write;
    wire  [4:0]  wr_num  = host_register_write ? host_register_num : supervisor_debug_num;
    wire  [31:0] wr_data = host_register_write ? host_register_data : supervisor_debug_data;

    // register selects
    wire sel_mask   = wr_en && (wr_num == `RN_PC_MATCH_MASK);
    wire sel_prim   = wr_en && (wr_num == `RN_PC_MATCH_PRIMARY);
    wire sel_second = wr_en && (wr_num == `RN_PC_MATCH_SECOND);
    wire sel_third  = wr_en && (wr_num == `RN_PC_MATCH_THIRD);
    wire sel_fourth = wr_en && (wr_num == `RN_PC_MATCH_FOURTH);
    wire trig_wr    = wr_en && (wr_num == `RN_TRIGGER_SETUP);

    logic [31:0] pc_match_mask;
    logic [31:0] pc_match_primary;
    logic [31:0] pc_match_second;
    logic [31:0] pc_match_third;
    logic [31:0] pc_match_fourth;
    logic [31:0] trigger_setup;

    // ============================================================
    // breakpoint registers
    // no interlock: loading while enabled may fire on half-loaded values
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_match_mask <= `REG_RST;
        end else if (sel_mask) begin
            pc_match_mask <= wr_data;
        end
    end

    // bit 0 is not stored so it can only read zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_match_primary <= `REG_RST;
        end else if (sel_prim) begin
            pc_match_primary <= {wr_data[31:1], 1'b0};
        end
    end

    // secondary registers keep their valid flag in bit 0
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_match_second <= `REG_RST;
        end else if (sel_second) begin
            pc_match_second <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_match_third <= `REG_RST;
        end else if (sel_third) begin
            pc_match_third <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_match_fourth <= `REG_RST;
        end else if (sel_fourth) begin
            pc_match_fourth <= wr_data;
        end
    end

    // trigger setup; reset leaves every enable clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trigger_setup <= `REG_RST;
        end else if (trig_wr) begin
            trigger_setup <= wr_data;
        end
    end

    // ============================================================
    // match units
    trig_cfg_if cfg ();

    // drive the bundle from registers and core inputs
    assign cfg.pc_now    = pc;
    assign cfg.pc_prim   = pc_match_primary;
    assign cfg.pc_sec[0] = pc_match_second;
    assign cfg.pc_sec[1] = pc_match_third;
    assign cfg.pc_sec[2] = pc_match_fourth;
    assign cfg.pc_mask   = pc_match_mask;
    assign cfg.bus_data  = data_bus;
    assign cfg.cmp_value = data_match_value;
    assign cfg.cmp_mask  = data_match_mask;
    assign cfg.bus_addr  = data_addr;
    assign cfg.bus_size  = data_size;
    assign cfg.bus_valid = data_valid;

    pc_match_unit u_pc_match (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cfg     (cfg)
    );

    data_match_unit u_data_match (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cfg     (cfg)
    );

    // ============================================================
    // level evaluation
    wire pc_trig_pkg::level_cfg_s l1_cfg = half_cfg(trigger_setup[15:0]);
    wire pc_trig_pkg::level_cfg_s l2_cfg = half_cfg(trigger_setup[31:16]);
    wire [1:0] trigger_response_select       = trigger_setup[`TRC_HI:`TRC_LO];
    wire       global_en = trigger_setup[16 + `HALF_EBL] | trigger_setup[`HALF_EBL]
                           | ext_global_enable;
    wire       l2_used   = l2_cfg.pc_en | (|l2_cfg.data_en);
    wire       l1_met    = level_met(l1_cfg, cfg.pc_hit, pc_valid, cfg.lane_app, cfg.lane_eq);
    wire       l2_met    = level_met(l2_cfg, cfg.pc_hit, pc_valid, cfg.lane_app, cfg.lane_eq);

    // ============================================================
    // trigger sequencer
    pc_trig_pkg::arm_level_e arm_level;
    pc_trig_pkg::arm_level_e next_arm_level;
    logic [3:0]              next_status;

    // level two is only looked at once level one has fired
    wire l1_fire  = global_en && (arm_level == pc_trig_pkg::ARM_FIRST) && l1_met;
    wire l2_fire  = global_en && (arm_level == pc_trig_pkg::ARM_SECOND) && l2_met;
    wire arm_up   = l1_fire && l2_used;
    wire complete = (l1_fire && !l2_used) || l2_fire;

    // next level; a setup write rearms unless the same cycle arms level two or completes
    always_comb begin
        case (arm_level)
            pc_trig_pkg::ARM_FIRST: begin
                next_arm_level = complete ? pc_trig_pkg::FIRED
                               : (arm_up ? pc_trig_pkg::ARM_SECOND : pc_trig_pkg::ARM_FIRST);
            end
            pc_trig_pkg::ARM_SECOND: begin
                next_arm_level = l2_fire ? pc_trig_pkg::FIRED : pc_trig_pkg::ARM_SECOND;
            end
            pc_trig_pkg::FIRED: begin
                next_arm_level = pc_trig_pkg::FIRED;
            end
            default: begin
                next_arm_level = pc_trig_pkg::ARM_FIRST;
            end
        endcase
        if (trig_wr && !arm_up && !complete) begin
            next_arm_level = pc_trig_pkg::ARM_FIRST;
        end
    end

    // status: a hit in the clearing cycle wins over the clear
    assign next_status = complete ? (l2_fire ? `ST_L2_DONE : `ST_L1_DONE)
                       : arm_up ? `ST_L2_ARMED
                       : trig_wr ? `ST_IDLE
                       : trigger_status_field;

    // sequencer state and status, cleared at reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            arm_level            <= pc_trig_pkg::ARM_FIRST;
            trigger_status_field <= `ST_IDLE;
        end else begin
            arm_level            <= next_arm_level;
            trigger_status_field <= next_status;
        end
    end

    // ============================================================
    // responses, one-cycle pulses
    // trace reports every completion regardless of the response chosen
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trace_strobe        <= 1'b0;
            trace_status_output <= `ST_IDLE;
            halt_request        <= 1'b0;
            debug_interrupt     <= 1'b0;
        end else begin
            trace_strobe        <= complete;
            trace_status_output <= complete ? next_status : `ST_IDLE;
            halt_request        <= complete && (trigger_response_select == `TRC_HALT);
            debug_interrupt     <= complete && (trigger_response_select == `TRC_IRQ);
        end
    end

    // ============================================================
    // host read port; mask is write-only and reads zero
    wire [31:0] rd_word = (host_read_num == `RN_PC_MATCH_PRIMARY) ? pc_match_primary
                        : (host_read_num == `RN_PC_MATCH_SECOND)  ? pc_match_second
                        : (host_read_num == `RN_PC_MATCH_THIRD)   ? pc_match_third
                        : (host_read_num == `RN_PC_MATCH_FOURTH)  ? pc_match_fourth
                        : (host_read_num == `RN_TRIGGER_SETUP)    ? trigger_setup
                        : `REG_RST;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_read_data  <= `REG_RST;
            host_read_valid <= 1'b0;
        end else begin
            host_read_data  <= host_register_read ? rd_word : `REG_RST;
            host_read_valid <= host_register_read;
        end
    end

    // ============================================================
    // checks
    chk_prim_bit_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pc_match_primary[0] == 1'b0) else $error("primary bit 0 not zero");

    chk_mask_write_num: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (supervisor_debug_write && !host_register_write && supervisor_debug_num == 5'h09)
        |=> pc_match_mask == $past(supervisor_debug_data)) else $error("mask not written");

    chk_setup_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (trig_wr && !complete && !arm_up) |=> (trigger_status_field == 4'h0 && arm_level == pc_trig_pkg::ARM_FIRST))
        else $error("setup write did not clear status");

    chk_halt_resp: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (complete && trigger_setup[31:30] == 2'h1) |=> (halt_request && !debug_interrupt))
        else $error("halt response missing");

    chk_irq_resp: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (complete && trigger_setup[31:30] == 2'h2) |=> (debug_interrupt && !halt_request))
        else $error("interrupt response missing");

    chk_trace_report: assert property (@(posedge ref_clk) disable iff (!rst_n)
        trace_strobe == $past(complete) && (!trace_strobe || trace_status_output != 4'h0))
        else $error("completion not traced");

    chk_disabled_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!trigger_setup[29] && !trigger_setup[13] && !ext_global_enable) |=> !trace_strobe)
        else $error("trigger while disabled");

    chk_pc_enable_need: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!trigger_setup[1] && trigger_setup[12:6] == 7'h00 && arm_level == pc_trig_pkg::ARM_FIRST)
        |=> !trace_strobe && trigger_status_field != 4'h2) else $error("level one fired unconfigured");

    chk_second_after_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (trigger_status_field == 4'h5) |-> $past(arm_level) == pc_trig_pkg::ARM_SECOND ||
        $past(trigger_status_field) == 4'h5) else $error("level two without level one");

    chk_pc_invert: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (global_en && arm_level == pc_trig_pkg::ARM_FIRST && trigger_setup[1:0] == 2'h3 &&
         trigger_setup[12:6] == 7'h00 && !l2_used && pc_valid && !cfg.pc_hit) |=> trace_strobe)
        else $error("inverted pc outside region missed");
endmodule // pc_breakpoint_trigger_control

/* File: rtl/pc_match_unit.sv */
/*
 * combinational pc comparison against the primary and three secondary registers.
 * assumes registers and pc arrive through the interface, one clock domain.
 */
`timescale 1ns/1ps
module pc_match_unit (
    input  wire logic ref_clk,   // clock, checks only
    input  wire logic rst_n,     // reset, checks only
    trig_cfg_if.pcu   cfg        // pc and match registers
);
    // ============================================================
    // compare
    wire [31:0] prim_diff = (cfg.pc_now ^ cfg.pc_prim) & ~cfg.pc_mask;
    wire        prim_hit  = (prim_diff == 32'h0000_0000);
    logic [2:0] sec_hit;
    // secondaries unmasked, bits 31..1, gated by their valid bit
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            sec_hit[i] = cfg.pc_sec[i][`PC_VALID] && (cfg.pc_sec[i][31:1] == cfg.pc_now[31:1]);
        end
    end
    assign cfg.pc_hit = prim_hit | (|sec_hit);

    chk_mask_all_ignore: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cfg.pc_mask == 32'hFFFF_FFFF) |-> cfg.pc_hit) else $error("full mask must hit");
    chk_sec_need_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!prim_hit && !cfg.pc_sec[0][0] && !cfg.pc_sec[1][0] && !cfg.pc_sec[2][0]) |-> !cfg.pc_hit)
        else $error("invalid secondary matched");
endmodule // pc_match_unit
